/* File: hdcw_pkg.sv */
package hdcw_pkg;

  localparam int unsigned CTRL_BITS = 8;
  localparam int unsigned REPLY_MAX = 16;
  localparam logic [4:0] REPLY_MIN_LEN = 5'h04;
  localparam logic [4:0] REPLY_MAX_LEN = 5'h10;
  localparam logic [4:0] CTRL_LAST_BIT = 5'h07;

  // Serial clock half period in clk_sys cycles
  localparam int unsigned SCK_HALF_DEF = 4;
  localparam int unsigned SCK_HALF_MIN = 3;

  localparam logic CS_IDLE_N = 1'b1;
  localparam logic SCK_IDLE = 1'b0;
  localparam logic SO_IDLE = 1'b0;

  typedef enum logic [2:0] {
    M_IDLE = 3'b000,
    M_CTRL = 3'b001,
    M_WAIT = 3'b010,
    M_REPLY = 3'b011,
    M_TAIL = 3'b100
  } hdcw_mst_t;

  typedef enum logic [1:0] {
    S_CTRL = 2'b00,
    S_WAIT = 2'b01,
    S_REPLY = 2'b10
  } hdcw_slv_t;

  function automatic logic [4:0] hdcw_clamp_len(input logic [4:0] n);
    logic [4:0] r;
    r = n;
    if (n < REPLY_MIN_LEN) begin
      r = REPLY_MIN_LEN;
    end else if (n > REPLY_MAX_LEN) begin
      r = REPLY_MAX_LEN;
    end
    return r;
  endfunction : hdcw_clamp_len

endpackage : hdcw_pkg

/* File: hdcw_link_if.sv */
`timescale 1ns/1ps
interface hdcw_link_if;
  logic [7:0] ctrl_word;
  logic ctrl_tgl;
  logic [15:0] reply_word;
  logic [4:0] reply_len;

  modport main (
    input ctrl_word,
    input ctrl_tgl,
    output reply_word,
    output reply_len
  );

  modport slave (
    output ctrl_word,
    output ctrl_tgl,
    input reply_word,
    input reply_len
  );
endinterface : hdcw_link_if

/* File: hdcw_slave.sv */
`timescale 1ns/1ps
module hdcw_slave
  import hdcw_pkg::*;
(
  input wire logic serial_clock_in,
  input wire logic sys_rst,
  input wire logic cs_in_n,
  input wire logic si,
  output logic slave_so,
  output logic slave_so_oe,
  hdcw_link_if.slave lnk
);

  logic rst_l1_q;
  logic rst_l2_q;
  hdcw_slv_t st_q;
  logic [4:0] cnt_q;
  logic [7:0] sh_q;
  logic [7:0] word_q;
  logic tgl_q;
  logic [4:0] dcnt_q;
  logic so_q;
  logic oe_q;

  // Link clock may stop between frames; chip select high also clears state
  always_ff @(posedge serial_clock_in) begin
    rst_l1_q <= sys_rst;
    rst_l2_q <= rst_l1_q;
  end

  wire frame_off = rst_l2_q | cs_in_n;
  wire [4:0] idx_full = 5'(lnk.reply_len - 5'h01 - dcnt_q);
  wire [3:0] idx = idx_full[3:0];

  always_ff @(posedge serial_clock_in) begin
    if (frame_off) begin
      st_q <= S_CTRL;
      cnt_q <= 5'h00;
    end else begin
      unique case (st_q)
        S_CTRL: begin
          sh_q <= {sh_q[6:0], si};
          cnt_q <= 5'(cnt_q + 5'h01);
          if (cnt_q == CTRL_LAST_BIT) begin
            st_q <= S_WAIT;
            cnt_q <= 5'h00;
          end
        end
        S_WAIT: st_q <= S_REPLY;
        default: st_q <= S_CTRL;
        S_REPLY: begin
          cnt_q <= 5'(cnt_q + 5'h01);
          if (5'(cnt_q + 5'h01) == lnk.reply_len) begin
            st_q <= S_CTRL;
            cnt_q <= 5'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge serial_clock_in) begin
    if (rst_l2_q) begin
      tgl_q <= 1'b0;
      word_q <= 8'h00;
    end else if (!cs_in_n && st_q == S_CTRL && cnt_q == CTRL_LAST_BIT) begin
      word_q <= {sh_q[6:0], si};
      tgl_q <= ~tgl_q;
    end
  end

  always_ff @(negedge serial_clock_in) begin
    if (frame_off || st_q != S_REPLY) begin
      oe_q <= 1'b0;
      so_q <= SO_IDLE;
      dcnt_q <= 5'h00;
    end else if (dcnt_q < lnk.reply_len) begin
      // Reply driven on falling edges, msb first
      so_q <= lnk.reply_word[idx];
      oe_q <= 1'b1;
      dcnt_q <= 5'(dcnt_q + 5'h01);
    end else begin
      oe_q <= 1'b0;
      so_q <= SO_IDLE;
    end
  end

  assign lnk.ctrl_word = word_q;
  assign lnk.ctrl_tgl = tgl_q;
  assign slave_so = so_q;
  assign slave_so_oe = oe_q;

endmodule : hdcw_slave

/* File: hdcw_engine.sv */
`timescale 1ns/1ps
module hdcw_engine
  import hdcw_pkg::*;
#(
  parameter int unsigned SCK_HALF = SCK_HALF_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serial_clock_in,
  input wire logic cs_in_n,
  input wire logic si,
  input wire logic master_mode,
  input wire logic cont_mode,
  input wire logic [4:0] data_size,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic [15:0] slave_reply_data,
  output logic tx_taken,
  output logic rx_valid,
  output logic [15:0] rx_data,
  output logic serial_clock_out,
  output logic cs_out_n,
  output logic so,
  output logic slave_so,
  output logic slave_so_oe,
  output logic slave_ctrl_valid,
  output logic [7:0] slave_ctrl_data,
  output logic busy
);

  // Refused at elaboration: below the minimum the synchroniser lag eats the half period
  if (SCK_HALF < SCK_HALF_MIN || SCK_HALF > 255) begin : g_half_chk
    $error("SCK_HALF out of range");
  end

  hdcw_link_if lnk ();

  hdcw_slave u_slave (
    .serial_clock_in(serial_clock_in),
    .sys_rst(sys_rst),
    .cs_in_n(cs_in_n),
    .si(si),
    .slave_so(slave_so),
    .slave_so_oe(slave_so_oe),
    .lnk(lnk)
  );

  localparam logic [7:0] HALF_LAST = 8'(SCK_HALF - 1);

  hdcw_mst_t st_q, st_d;
  logic [7:0] half_q, half_d;
  logic sclk_q, sclk_d;
  logic cs_n_q, cs_n_d;
  logic so_q, so_d;
  logic [7:0] sh_q, sh_d;
  logic [4:0] bit_q, bit_d;
  logic [4:0] len_q, len_d;
  logic [15:0] rx_q, rx_d;
  logic rxv_q, rxv_d;
  logic [15:0] rxd_q, rxd_d;
  logic taken_q, taken_d;
  logic busy_q;
  logic si_m_q, si_s_q;
  logic tg1_q, tg2_q, tg3_q;
  logic cv_q;
  logic [7:0] cd_q;
  logic [15:0] reply_q;
  logic [4:0] slen_q;

  // Serial input crosses into clk_sys; half period must exceed the latency
  always_ff @(posedge clk_sys) begin
    si_m_q <= si;
    si_s_q <= si_m_q;
  end

  wire active = (st_q == M_CTRL) || (st_q == M_WAIT) || (st_q == M_REPLY);
  wire tick = (st_q != M_IDLE) && (half_q == HALF_LAST);
  wire rise = tick && active && !sclk_q;
  wire fall = tick && active && sclk_q;
  wire last_fall = (st_q == M_REPLY) && fall && (bit_q == len_q);
  wire start_idle = (st_q == M_IDLE) && master_mode && tx_valid;
  wire start_cont = last_fall && cont_mode && tx_valid;
  wire start_now = start_idle || start_cont;

  always_comb begin
    st_d = st_q;
    sclk_d = sclk_q;
    cs_n_d = cs_n_q;
    so_d = so_q;
    sh_d = sh_q;
    bit_d = bit_q;
    len_d = len_q;
    rx_d = rx_q;
    rxv_d = 1'b0;
    rxd_d = rxd_q;
    taken_d = 1'b0;
    half_d = (st_q == M_IDLE || tick) ? 8'h00 : 8'(half_q + 8'h01);
    unique case (st_q)
      M_IDLE: begin
        sclk_d = SCK_IDLE;
        cs_n_d = CS_IDLE_N;
        so_d = SO_IDLE;
      end
      M_CTRL: begin
        if (rise) begin
          sclk_d = 1'b1;
        end
        if (fall) begin
          sclk_d = 1'b0;
          if (bit_q == CTRL_LAST_BIT) begin
            st_d = M_WAIT;
            so_d = SO_IDLE;
            bit_d = 5'h00;
          end else begin
            sh_d = {sh_q[6:0], 1'b0};
            so_d = sh_q[6];
            bit_d = 5'(bit_q + 5'h01);
          end
        end
      end
      M_WAIT: begin
        // Slave decode period; no sample here
        if (rise) begin
          sclk_d = 1'b1;
        end
        if (fall) begin
          sclk_d = 1'b0;
          st_d = M_REPLY;
        end
      end
      M_REPLY: begin
        if (rise) begin
          sclk_d = 1'b1;
          rx_d = {rx_q[14:0], si_s_q};
          bit_d = 5'(bit_q + 5'h01);
        end
        if (fall) begin
          sclk_d = 1'b0;
        end
        if (start_cont) begin
          rxv_d = 1'b1;
          rxd_d = rx_q;
        end else if (last_fall) begin
          st_d = M_TAIL;
        end
      end
      M_TAIL: begin
        if (tick) begin
          cs_n_d = CS_IDLE_N;
          rxv_d = 1'b1;
          rxd_d = rx_q;
          st_d = M_IDLE;
        end
      end
      default: begin
        st_d = M_IDLE;
        sclk_d = SCK_IDLE;
        cs_n_d = CS_IDLE_N;
        so_d = SO_IDLE;
      end
    endcase
    if (start_now) begin
      sh_d = tx_data;
      so_d = tx_data[7];
      cs_n_d = 1'b0;
      bit_d = 5'h00;
      rx_d = 16'h0000;
      len_d = hdcw_clamp_len(data_size);
      taken_d = 1'b1;
      st_d = M_CTRL;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      st_q <= M_IDLE;
      half_q <= 8'h00;
      sclk_q <= SCK_IDLE;
      cs_n_q <= CS_IDLE_N;
      so_q <= SO_IDLE;
    end else begin
      st_q <= st_d;
      half_q <= half_d;
      sclk_q <= sclk_d;
      cs_n_q <= cs_n_d;
      so_q <= so_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sh_q <= 8'h00;
      bit_q <= 5'h00;
      len_q <= REPLY_MIN_LEN;
      rx_q <= 16'h0000;
      rxv_q <= 1'b0;
      rxd_q <= 16'h0000;
      taken_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      sh_q <= sh_d;
      bit_q <= bit_d;
      len_q <= len_d;
      rx_q <= rx_d;
      rxv_q <= rxv_d;
      rxd_q <= rxd_d;
      taken_q <= taken_d;
      busy_q <= (st_d != M_IDLE);
    end
  end

  // Control word from the link domain arrives by toggle; word is stable a frame
  wire ctrl_evt = tg2_q ^ tg3_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tg1_q <= 1'b0;
      tg2_q <= 1'b0;
      tg3_q <= 1'b0;
      cv_q <= 1'b0;
      cd_q <= 8'h00;
      reply_q <= 16'h0000;
      slen_q <= REPLY_MIN_LEN;
    end else begin
      tg1_q <= lnk.ctrl_tgl;
      tg2_q <= tg1_q;
      tg3_q <= tg2_q;
      cv_q <= ctrl_evt;
      if (ctrl_evt) begin
        cd_q <= lnk.ctrl_word;
      end
      // Quasi-static: must not change while a slave frame runs
      reply_q <= slave_reply_data;
      slen_q <= hdcw_clamp_len(data_size);
    end
  end

  assign lnk.reply_word = reply_q;
  assign lnk.reply_len = slen_q;

  assign tx_taken = taken_q;
  assign rx_valid = rxv_q;
  assign rx_data = rxd_q;
  assign serial_clock_out = sclk_q;
  assign cs_out_n = cs_n_q;
  assign so = so_q;
  assign slave_ctrl_valid = cv_q;
  assign slave_ctrl_data = cd_q;
  assign busy = busy_q;

endmodule : hdcw_engine

/* File: hdcw_checker.sv */
`timescale 1ns/1ps
module hdcw_checker (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic master_mode,
  input wire logic [4:0] data_size,
  input wire logic tx_valid,
  input wire logic tx_taken,
  input wire logic rx_valid,
  input wire logic serial_clock_out,
  input wire logic cs_out_n,
  input wire logic so,
  input wire logic busy
);
  logic [4:0] ds_q;
  logic [5:0] n_q;
  logic [5:0] l_q;
  wire [5:0] len_w = (ds_q < 5'h04) ? 6'h04 : (ds_q > 5'h10) ? 6'h10 : {1'b0, ds_q};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Rising clock edges since the last take
  always_ff @(posedge clk_sys) begin
    ds_q <= data_size;
    if (sys_rst) begin
      n_q <= 6'h00;
      l_q <= 6'h00;
    end else if (tx_taken) begin
      n_q <= 6'h00;
      l_q <= len_w;
    end else if ($rose(serial_clock_out)) begin
      n_q <= n_q + 6'h01;
    end
  end
  idle_lines_a: assert property (!busy |-> !serial_clock_out && cs_out_n && !so)
    else $error("idle lines wrong");
  start_take_a: assert property (!busy && master_mode && tx_valid |=> tx_taken)
    else $error("offered byte not taken");
  cs_fall_a: assert property ($fell(cs_out_n) |-> tx_taken && busy)
    else $error("select fell without take");
  frame_hold_a: assert property (busy |-> !cs_out_n)
    else $error("select high in frame");
  single_end_a: assert property ($rose(cs_out_n) |->
    rx_valid && !$past(serial_clock_out, 2))
    else $error("bad single frame end");
  cont_load_a: assert property (rx_valid && !cs_out_n |-> tx_taken)
    else $error("no reload in continuous run");
  take_pulse_a: assert property (tx_taken |=> !tx_taken [*2])
    else $error("take pulse too long");
  frame_len_a: assert property (rx_valid |-> n_q == l_q + 6'h09)
    else $error("wrong frame length");
  single_c: cover property ($rose(cs_out_n));
  cont_c: cover property (rx_valid && tx_taken);
  start_c: cover property ($fell(cs_out_n));
endmodule : hdcw_checker

bind hdcw_engine hdcw_checker u_chk (.clk_sys(clk_sys), .sys_rst(sys_rst),
  .master_mode(master_mode), .data_size(data_size), .tx_valid(tx_valid),
  .tx_taken(tx_taken), .rx_valid(rx_valid), .serial_clock_out(serial_clock_out),
  .cs_out_n(cs_out_n), .so(so), .busy(busy));

/* File: hdcw_far_slave.sv */
`timescale 1ns/1ps
module hdcw_far_slave (
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic [4:0] len,
  input wire logic [15:0] reply,
  output logic miso,
  output logic [7:0] ctrl
);
  logic [4:0] r_q;
  initial miso = 1'b0;
  always @(posedge sck or posedge cs_n) begin
    if (cs_n) begin
      r_q <= 5'h00;
    end else begin
      if (r_q < 5'h08) begin
        ctrl <= {ctrl[6:0], mosi};
      end
      r_q <= (r_q == len + 5'h08) ? 5'h00 : r_q + 5'h01;
    end
  end
  // wait bit, reply on fall, then a toggling line
  always @(negedge sck) begin
    miso <= (r_q > 5'h08) ? reply[len + 5'h08 - r_q] : ~miso;
  end
endmodule : hdcw_far_slave

/* File: tb_halfduplex_ctrl_word_serial.sv */
`timescale 1ns/1ps
module tb_halfduplex_ctrl_word_serial;
  logic clk_sys = 0, sys_rst = 1, sck_in = 0, cs_in_n = 1, tb_si = 0, master_mode = 1;
  logic cont_mode = 0, tx_valid = 0, o, oe_s;
  logic [4:0] data_size = 5'h04, m_len = 5'h04;
  logic [7:0] tx_data = 8'h00, far_ctrl, sv_seen, b;
  logic [15:0] srep = 16'h0000, m_reply = 16'h0000, rx_data, got;
  logic tx_taken, rx_valid, sck_out, cs_out_n, so, s_so, s_oe, s_cv, busy, far_si;
  logic [7:0] s_cd;
  logic [15:0] exp_q[$];
  logic [7:0] ctl_q[$];
  int errors = 0, check_count = 0;
  wire si_w = master_mode ? far_si : tb_si;
  hdcw_engine #(.SCK_HALF(3)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .serial_clock_in(sck_in), .cs_in_n(cs_in_n), .si(si_w), .master_mode(master_mode),
    .cont_mode(cont_mode), .data_size(data_size), .tx_valid(tx_valid), .tx_data(tx_data),
    .slave_reply_data(srep), .tx_taken(tx_taken), .rx_valid(rx_valid), .rx_data(rx_data),
    .serial_clock_out(sck_out), .cs_out_n(cs_out_n), .so(so), .slave_so(s_so),
    .slave_so_oe(s_oe), .slave_ctrl_valid(s_cv), .slave_ctrl_data(s_cd), .busy(busy));
  hdcw_far_slave far (.sck(sck_out), .cs_n(cs_out_n), .mosi(so), .len(m_len),
    .reply(m_reply), .miso(far_si), .ctrl(far_ctrl));
  function automatic logic [4:0] exp_len(input logic [4:0] d);
    return (d < 5'h04) ? 5'h04 : (d > 5'h10) ? 5'h10 : d;
  endfunction : exp_len
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("errors %0d checks %0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : final_report
  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask : tick
  // Offer one byte, hold it until taken; last drops the offer
  task automatic frame(input logic c, input logic last, input logic [4:0] ds);
    int n;
    logic [15:0] rp;
    rp = $urandom;
    tx_data = $urandom;
    data_size = ds;
    cont_mode = c;
    tx_valid = 1'b1;
    n = 0;
    do begin tick(); n++; end while (tx_taken !== 1'b1 && n < 400);
    chk("tx_taken", {15'h0000, tx_taken}, 16'h0001);
    m_len = exp_len(ds);
    m_reply = rp;
    exp_q.push_back(rp & 16'((32'h1 << m_len) - 32'h1));
    ctl_q.push_back(tx_data);
    if (last) begin
      tx_valid = 1'b0;
      n = 0;
      do begin tick(); n++; end while (busy !== 1'b0 && n < 400);
      chk("busy", {15'h0000, busy}, 16'h0000);
    end
  endtask : frame
  // One link clock cycle, slave_so sampled before the rise
  task automatic lk(input logic bit_in);
    tb_si = bit_in;
    #24;
    o = slave_so_w();
    oe_s = s_oe;
    sck_in = 1;
    #24;
    sck_in = 0;
  endtask : lk
  function automatic logic slave_so_w();
    return s_so;
  endfunction : slave_so_w
  always @(negedge clk_sys) begin
    if (rx_valid === 1'b1) begin
      chk("rx_data", rx_data, exp_q.pop_front());
      chk("ctrl", {8'h00, far_ctrl}, {8'h00, ctl_q.pop_front()});
    end
    if (s_cv === 1'b1) begin
      sv_seen = s_cd;
    end
  end
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errors++;
    final_report();
  end
  initial begin
    void'($urandom(51));
    // Link clock runs in reset so the slave side clears too
    fork
      repeat (8) @(posedge clk_sys);
      repeat (4) lk(1'b0);
    join
    #1 sys_rst = 0;
    for (int i = 0; i < 12; i++) begin
      frame(i > 5, i < 6 || i == 11, i == 0 ? 5'h00 : i == 1 ? 5'h1f : 5'($urandom_range(16, 4)));
    end
    master_mode = 0;
    srep = $urandom;
    data_size = 5'($urandom_range(16, 4));
    // select high a period past the last rise, low two periods ahead
    repeat (3) lk(1'b0);
    #31 cs_in_n = 0;
    #96;
    // Two slave frames back to back, select held low
    for (int f = 0; f < 2; f++) begin
      b = $urandom;
      for (int k = 7; k >= 0; k--) lk(b[k]);
      lk(1'b0);
      for (int k = 15; k >= 0; k--) begin
        got[k] = 1'b0;
        if (k < data_size) begin
          lk(1'b0);
          got[k] = o;
          chk("slave_oe", {15'h0000, oe_s}, 16'h0001);
        end
      end
      // first rise after select samples bit 7
      chk("slave_ctrl", {8'h00, sv_seen}, {8'h00, b});
      chk("slave_reply", got, srep & 16'((32'h1 << data_size) - 32'h1));
    end
    #24 cs_in_n = 1;
    repeat (10) tick();
    chk("slave_oe", {15'h0000, s_oe}, 16'h0000);
    // every word pushed for a taken frame was popped on rx_valid
    chk("pending", 16'(exp_q.size()), 16'h0000);
    final_report();
  end
endmodule : tb_halfduplex_ctrl_word_serial
